// ==== cseb_pkg.sv ====
package cseb_pkg;

  // ****************************************************************
  // region map: four chip-select regions, then two dynamic banks
  // ****************************************************************
  localparam int NUM_CS = 4;
  localparam int NUM_REGION = 6;
  localparam logic [2:0] DRAM_FIRST = 3'h4;
  localparam logic [2:0] REGION_LAST = 3'h5;

  // ****************************************************************
  // reset values of each region's settings
  // ****************************************************************
  localparam logic [3:0] WAIT_RESET = 4'hf;
  localparam logic [7:0] BASE_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic EXT_ACK_RESET = 1'b0;
  localparam logic PORT16_RESET = 1'b1;
  localparam int BOOT_REGION = 0;

  // ****************************************************************
  // operand sizes and dynamic memory row position
  // ****************************************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam int DRAM_ROW_SHIFT = 11;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [23:0] addr;
    logic write;
    logic [1:0] size;
    logic burst;
    logic [31:0] wdata;
  } cseb_req_t;

  typedef struct packed {
    logic error;
    logic [31:0] rdata;
  } cseb_rsp_t;

  typedef struct packed {
    logic valid;
    logic [7:0] base;
    logic [7:0] mask;
    logic [3:0] wait_cycle_count;
    logic ext_ack;
    logic port16;
  } cseb_cfg_t;

  typedef struct packed {
    logic rw_gpio;
    logic sel1_gpio;
    logic oe_gpio;
  } cseb_pinfn_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_WAIT = 3'h2,
    ST_DATA = 3'h3,
    ST_HOLD = 3'h4
  } cseb_state_t;

endpackage

// ==== cseb_slave_model.sv ====
`timescale 1ns/1ps
module cseb_slave_model (
  // bus pins seen from the slave
  input wire logic clock,
  input wire logic [23:1] addr_out,
  input wire logic read_write_n,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe_n,
  input wire logic [3:0] cs_n,
  input wire logic output_enable_n,
  output logic [15:0] data_in,
  output logic ack_n,
  output logic err_n,
  // scenario controls
  input wire logic ack_en,
  input wire logic [3:0] ack_delay,
  input wire logic err_en
);
  logic [15:0] mem [256];
  logic [15:0] last_q = 16'h0000;
  logic [3:0] cnt_q = 4'h0;
  logic sel;

  assign sel = (cs_n != 4'hf);
  // released bus toggles so a stale value never passes as read data
  assign data_in = (sel && !output_enable_n) ? mem[addr_out[8:1]] : ~last_q;
  // store only while all lanes are driven; count cycles of select
  always @(posedge clock) begin
    last_q <= data_in;
    if (sel && !read_write_n && data_oe_n == 16'h0000) begin
      mem[addr_out[8:1]] <= data_out;
    end
    cnt_q <= sel ? cnt_q + 4'h1 : 4'h0;
  end
  // acknowledge falls ack_delay clocks after the select and rises with it; off means held high
  assign ack_n = !(ack_en && sel && cnt_q >= ack_delay);
  assign err_n = !(err_en && sel);
endmodule

// ==== cseb_top.sv ====
`timescale 1ns/1ps

module cseb_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // internal request and answer
  input wire logic req_valid,
  output logic req_ready,
  input wire cseb_pkg::cseb_req_t req,
  output logic rsp_valid,
  output cseb_pkg::cseb_rsp_t rsp,
  input wire logic system_bus_controller_region_hit,
  // configuration
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_sel,
  input wire cseb_pkg::cseb_cfg_t cfg_data,
  input wire logic pinfn_wr,
  input wire cseb_pkg::cseb_pinfn_t pinfn_data,
  output cseb_pkg::cseb_pinfn_t pinfn,
  // general purpose values for shared pins
  input wire logic shared_io_nine,
  input wire logic shared_io_one,
  input wire logic shared_output_forty,
  // external bus pins
  output logic [23:1] addr_out,
  output logic read_write_n,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [15:0] data_oe_n,
  output logic chip_select_zero_n,
  output logic chip_select_one_n,
  output logic chip_select_two_n,
  output logic chip_select_three_n,
  output logic output_enable_n,
  input wire logic transfer_acknowledge_in_n,
  input wire logic transfer_error_input_n
);

  // ****************************************************************
  // region settings
  // ****************************************************************
  cseb_pkg::cseb_cfg_t cfg_q [cseb_pkg::NUM_REGION];
  cseb_pkg::cseb_pinfn_t pinfn_q;

  // settings start at the safe boot profile until software rewrites them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < cseb_pkg::NUM_REGION; i++) begin
        cfg_q[i].valid <= (i == cseb_pkg::BOOT_REGION);
        cfg_q[i].base <= cseb_pkg::BASE_RESET;
        cfg_q[i].mask <= cseb_pkg::MASK_RESET;
        cfg_q[i].wait_cycle_count <= cseb_pkg::WAIT_RESET;
        cfg_q[i].ext_ack <= cseb_pkg::EXT_ACK_RESET;
        cfg_q[i].port16 <= cseb_pkg::PORT16_RESET;
      end
    end else begin
      for (int i = 0; i < cseb_pkg::NUM_REGION; i++) begin
        if (cfg_wr && cfg_sel == 3'(i)) begin
          cfg_q[i] <= cfg_data;
        end
      end
    end
  end

  // shared pins leave reset in their bus function
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pinfn_q <= '0;
    end else if (pinfn_wr) begin
      pinfn_q <= pinfn_data;
    end
  end

  assign pinfn = pinfn_q;

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic hit_any;
  logic [2:0] hit_idx;

  // lowest matching region wins; mask bits mark don't-care address bits
  always_comb begin
    hit_any = 1'b0;
    hit_idx = 3'h0;
    for (int i = cseb_pkg::NUM_REGION - 1; i >= 0; i--) begin
      if (cfg_q[i].valid && (((req.addr[23:16] ^ cfg_q[i].base) & ~cfg_q[i].mask) == 8'h00)) begin
        hit_any = 1'b1;
        hit_idx = 3'(i);
      end
    end
  end

  // ****************************************************************
  // transfer state
  // ****************************************************************
  cseb_pkg::cseb_state_t state_q;
  logic [23:0] addr_q;
  logic write_q;
  logic [1:0] size_q;
  logic burst_q;
  logic [2:0] region_q;
  logic is_dram_q;
  logic [3:0] wait_q;
  logic [2:0] beats_q;
  logic [31:0] data_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic rsp_valid_q;
  logic rsp_err_q;
  cseb_pkg::cseb_cfg_t cur_cfg;
  logic byte_beat;
  logic err_in_now;
  logic beat_done;
  logic [2:0] req_beats;
  logic [31:0] req_data;

  assign cur_cfg = cfg_q[region_q];
  assign byte_beat = !cur_cfg.port16 || size_q == cseb_pkg::SIZE_BYTE;
  assign err_in_now = !transfer_error_input_n;

  // beats per request: a longword on a 16-bit port is two halfwords
  always_comb begin
    req_data = req.wdata;
    req_beats = 3'h1;
    case (req.size)
      cseb_pkg::SIZE_BYTE: begin
        req_data = {req.wdata[7:0], req.wdata[7:0], 16'h0000};
      end
      cseb_pkg::SIZE_WORD: begin
        req_data = {req.wdata[15:0], 16'h0000};
        req_beats = cfg_q[hit_idx].port16 ? 3'h1 : 3'h2;
      end
      default: begin
        req_beats = cfg_q[hit_idx].port16 ? 3'h2 : 3'h4;
      end
    endcase
  end

  // ****************************************************************
  // acknowledge synchroniser and edge detect
  // ****************************************************************
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_s3_q;
  logic ack_edge;
  logic ack_pend_q;

  // slave may drive the acknowledge at any time, so retime it first
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
    end else begin
      ack_s1_q <= !transfer_acknowledge_in_n;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
    end
  end

  // a level held over from the last cycle makes no edge and is ignored
  assign ack_edge = ack_s2_q && !ack_s3_q;

  // pending edge is cleared in the hold and idle clocks, so it carries across burst beats; an edge in those clocks is lost
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_pend_q <= 1'b0;
    end else if (ack_edge && state_q inside {cseb_pkg::ST_ADDR, cseb_pkg::ST_WAIT,
                                             cseb_pkg::ST_DATA}) begin
      ack_pend_q <= 1'b1;
    end else if (state_q == cseb_pkg::ST_HOLD || state_q == cseb_pkg::ST_IDLE) begin
      ack_pend_q <= 1'b0;
    end
  end

  // dram ignores the pin; others use it only once enabled
  always_comb begin
    if (is_dram_q || !cur_cfg.ext_ack) begin
      beat_done = 1'b1;
    end else begin
      beat_done = ack_pend_q || ack_edge;
    end
  end

  // ****************************************************************
  // bus cycle sequencer
  // ****************************************************************
  assign req_ready = state_q == cseb_pkg::ST_IDLE;

  // address, then waits, then sample clock, then hold clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= cseb_pkg::ST_IDLE;
      wait_q <= 4'h0;
      beats_q <= 3'h0;
    end else begin
      case (state_q)
        cseb_pkg::ST_IDLE: begin
          if (req_valid && hit_any && !system_bus_controller_region_hit) begin
            state_q <= cseb_pkg::ST_ADDR;
            beats_q <= req_beats;
          end
        end
        cseb_pkg::ST_ADDR: begin
          wait_q <= cur_cfg.wait_cycle_count;
          if (cur_cfg.wait_cycle_count == 4'h0) begin
            state_q <= cseb_pkg::ST_DATA;
          end else begin
            state_q <= cseb_pkg::ST_WAIT;
          end
        end
        cseb_pkg::ST_WAIT: begin
          wait_q <= wait_q - 4'h1;
          if (wait_q == 4'h1) begin
            state_q <= cseb_pkg::ST_DATA;
          end
        end
        cseb_pkg::ST_DATA: begin
          if (beat_done || err_in_now) begin
            beats_q <= beats_q - 3'h1;
            // a burst skips the hold clock between its beats
            if (burst_q && !err_in_now && beats_q != 3'h1) begin
              state_q <= cseb_pkg::ST_ADDR;
            end else begin
              state_q <= cseb_pkg::ST_HOLD;
            end
          end
        end
        cseb_pkg::ST_HOLD: begin
          if (beats_q != 3'h0 && !err_q) begin
            state_q <= cseb_pkg::ST_ADDR;
          end else begin
            state_q <= cseb_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= cseb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // request attributes, address stepping and sticky error
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_q <= 24'h000000;
      write_q <= 1'b0;
      size_q <= cseb_pkg::SIZE_BYTE;
      burst_q <= 1'b0;
      region_q <= 3'h0;
      is_dram_q <= 1'b0;
      err_q <= 1'b0;
    end else if (state_q == cseb_pkg::ST_IDLE && req_valid) begin
      addr_q <= req.addr;
      write_q <= req.write;
      size_q <= req.size;
      burst_q <= req.burst;
      region_q <= hit_idx;
      is_dram_q <= hit_idx >= cseb_pkg::DRAM_FIRST;
      err_q <= 1'b0;
    end else if (state_q == cseb_pkg::ST_DATA && (beat_done || err_in_now)) begin
      err_q <= err_q || err_in_now;
      addr_q <= addr_q + (byte_beat ? 24'h000001 : 24'h000002);
    end
  end

  // ****************************************************************
  // data path
  // ****************************************************************
  // write data sits left-justified; upper halfword goes out first
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_q <= 32'h00000000;
    end else if (state_q == cseb_pkg::ST_IDLE && req_valid) begin
      data_q <= req_data;
    end else if (state_q == cseb_pkg::ST_DATA && beat_done) begin
      data_q <= byte_beat ? {data_q[23:0], 8'h00} : {data_q[15:0], 16'h0000};
    end
  end

  // read lanes: odd byte on a 16-bit port arrives on the low lane
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
    end else if (state_q == cseb_pkg::ST_IDLE && req_valid) begin
      rdata_q <= 32'h00000000;
    end else if (state_q == cseb_pkg::ST_DATA && beat_done && !write_q) begin
      if (!byte_beat) begin
        rdata_q <= {rdata_q[15:0], data_in};
      end else if (cur_cfg.port16 && addr_q[0]) begin
        rdata_q <= {rdata_q[23:0], data_in[7:0]};
      end else begin
        rdata_q <= {rdata_q[23:0], data_in[15:8]};
      end
    end
  end

  // answer pulse: after the last hold clock or at once without a bus cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_err_q <= 1'b0;
    end else if (state_q == cseb_pkg::ST_IDLE && req_valid && !hit_any) begin
      rsp_valid_q <= 1'b1;
      rsp_err_q <= !system_bus_controller_region_hit;
    end else if (state_q == cseb_pkg::ST_IDLE && req_valid &&
                 system_bus_controller_region_hit) begin
      rsp_valid_q <= 1'b1;
      rsp_err_q <= 1'b0;
    end else begin
      rsp_valid_q <= state_q == cseb_pkg::ST_HOLD && (beats_q == 3'h0 || err_q);
      rsp_err_q <= err_q;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp = '{error: rsp_err_q, rdata: rdata_q};

  // ****************************************************************
  // pins driven from rising-edge state
  // ****************************************************************
  logic bus_active;
  logic drive_data;

  assign bus_active = state_q inside {cseb_pkg::ST_ADDR, cseb_pkg::ST_WAIT, cseb_pkg::ST_DATA};
  // write data runs from end of first clock to end of the hold clock
  assign drive_data = write_q && state_q inside {cseb_pkg::ST_WAIT, cseb_pkg::ST_DATA,
                                                 cseb_pkg::ST_HOLD};

  // dram row in the first clock, column after; no A0 pin exists
  always_comb begin
    if (is_dram_q && state_q == cseb_pkg::ST_ADDR) begin
      addr_out = 23'(addr_q[23:1] >> cseb_pkg::DRAM_ROW_SHIFT);
    end else begin
      addr_out = addr_q[23:1];
    end
  end

  assign data_out = data_q[31:16];
  assign data_oe_n = drive_data ? 16'h0000 : 16'hffff;
  // direction changes on the same edge as the address
  assign read_write_n = pinfn_q.rw_gpio ? shared_io_nine : !write_q;

  // ****************************************************************
  // strobes on the falling edge
  // ****************************************************************
  logic [cseb_pkg::NUM_CS-1:0] cs_n_q;
  logic oe_n_q;

  // half a clock after the address, so it is settled when selects fall
  always_ff @(negedge clock or posedge rst) begin
    if (rst) begin
      cs_n_q <= 4'hf;
      oe_n_q <= 1'b1;
    end else begin
      for (int i = 0; i < cseb_pkg::NUM_CS; i++) begin
        cs_n_q[i] <= !(bus_active && !is_dram_q && region_q == 3'(i));
      end
      oe_n_q <= !(bus_active && !is_dram_q && !write_q);
    end
  end

  assign chip_select_zero_n = cs_n_q[0];
  assign chip_select_one_n = pinfn_q.sel1_gpio ? shared_io_one : cs_n_q[1];
  assign chip_select_two_n = cs_n_q[2];
  assign chip_select_three_n = cs_n_q[3];
  assign output_enable_n = pinfn_q.oe_gpio ? shared_output_forty : oe_n_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [4:0] beat_cyc_q;

  // clock number within a beat: the clock after the address clock is the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      beat_cyc_q <= 5'h0;
    end else if (state_q == cseb_pkg::ST_ADDR) begin
      beat_cyc_q <= 5'h2;
    end else if (bus_active) begin
      beat_cyc_q <= beat_cyc_q + 5'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  beat_length_a: assert property (
    (state_q == cseb_pkg::ST_DATA && (is_dram_q || !cur_cfg.ext_ack))
      |-> beat_cyc_q == 5'(cur_cfg.wait_cycle_count) + 5'h2)
    else $error("internal beat length differs from wait count");

  addr_stable_a: assert property (
    (state_q == cseb_pkg::ST_DATA && $past(state_q) != cseb_pkg::ST_ADDR)
      |-> $stable(addr_out) && $stable(read_write_n))
    else $error("address or direction moved inside a beat");

  unmatched_err_a: assert property (
    (req_valid && req_ready && !hit_any && !system_bus_controller_region_hit)
      |=> rsp_valid && rsp.error)
    else $error("unmatched address not ended with error");

  dram_noack_a: assert property (
    (state_q == cseb_pkg::ST_DATA && is_dram_q) |=> state_q != cseb_pkg::ST_DATA)
    else $error("dram beat waited for acknowledge");

  ack_wait_a: assert property (
    (state_q == cseb_pkg::ST_DATA && cur_cfg.ext_ack && !is_dram_q && !ack_pend_q
      && !ack_edge && transfer_error_input_n) |=> state_q == cseb_pkg::ST_DATA)
    else $error("beat ended without acknowledge edge");

  read_oe_a: assert property (
    (state_q == cseb_pkg::ST_DATA && !write_q && !is_dram_q && !pinfn_q.oe_gpio)
      |-> !output_enable_n)
    else $error("output enable high during read sample");

  write_drive_a: assert property (
    (state_q == cseb_pkg::ST_DATA && write_q) |-> data_oe_n == 16'h0000)
    else $error("write did not drive all data lines");

  cs_select_a: assert property (
    (state_q == cseb_pkg::ST_DATA && !is_dram_q && region_q == 3'h0) |-> !chip_select_zero_n)
    else $error("select zero not low in sample clock");

  err_input_a: assert property (
    (state_q == cseb_pkg::ST_DATA && !transfer_error_input_n) |-> ##[1:2] (rsp_valid && rsp.error))
    else $error("error input did not fail the transfer");

  half_order_a: assert property (
    (state_q == cseb_pkg::ST_DATA && beat_done && !byte_beat && transfer_error_input_n)
      |=> addr_q == $past(addr_q) + 24'h000002)
    else $error("second halfword address not two above first");

  read_cover: cover property (
    (state_q == cseb_pkg::ST_DATA && !write_q) ##1 state_q == cseb_pkg::ST_HOLD ##1 rsp_valid);
  long_write_cover: cover property (
    (state_q == cseb_pkg::ST_HOLD && write_q && beats_q == 3'h1) ##1 state_q == cseb_pkg::ST_ADDR);
  ext_ack_cover: cover property (
    state_q == cseb_pkg::ST_DATA && cur_cfg.ext_ack && ack_edge);
  error_cover: cover property (rsp_valid && rsp.error);

endmodule

// ==== tb_chip_select_external_bus.sv ====
`timescale 1ns/1ps
module tb_chip_select_external_bus;
  logic clock, rst, req_valid, req_ready, rsp_valid, sysbus_hit, cfg_wr, pinfn_wr;
  cseb_pkg::cseb_req_t req;
  cseb_pkg::cseb_rsp_t rsp, r;
  cseb_pkg::cseb_cfg_t cfg_data;
  cseb_pkg::cseb_pinfn_t pinfn_data, pinfn;
  logic [2:0] cfg_sel;
  logic gp_nine, gp_one, gp_forty, read_write_n, sel0_n, sel1_n, sel2_n, sel3_n, oe_n;
  logic ack_n, err_n, ack_en, err_en, seen_oe, seen_sel1, seen_drv, seen_row;
  logic [23:1] addr_out;
  logic [15:0] data_in, data_out, data_oe_n;
  logic [3:0] ack_delay;
  int error_cnt, n_compared, n;

  cseb_top uut (.clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .system_bus_controller_region_hit(sysbus_hit),
    .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_data(cfg_data), .pinfn_wr(pinfn_wr),
    .pinfn_data(pinfn_data), .pinfn(pinfn), .shared_io_nine(gp_nine),
    .shared_io_one(gp_one), .shared_output_forty(gp_forty), .addr_out(addr_out),
    .read_write_n(read_write_n), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .chip_select_zero_n(sel0_n), .chip_select_one_n(sel1_n),
    .chip_select_two_n(sel2_n), .chip_select_three_n(sel3_n), .output_enable_n(oe_n),
    .transfer_acknowledge_in_n(ack_n), .transfer_error_input_n(err_n));

  cseb_slave_model pm (.clock(clock), .addr_out(addr_out), .read_write_n(read_write_n),
    .data_out(data_out), .data_oe_n(data_oe_n), .cs_n({sel3_n, sel2_n, sel1_n, sel0_n}),
    .output_enable_n(oe_n), .data_in(data_in), .ack_n(ack_n), .err_n(err_n),
    .ack_en(ack_en), .ack_delay(ack_delay), .err_en(err_en));

  // ****************************************************************
  // clock, strobe monitor and helpers
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // strobes seen during the current access
  always @(posedge clock) begin
    if (oe_n === 1'b0) seen_oe = 1'b1;
    if (sel1_n === 1'b0) seen_sel1 = 1'b1;
    if (data_oe_n === 16'h0000) seen_drv = 1'b1;
    if (addr_out === 23'(24'h020000 >> (cseb_pkg::DRAM_ROW_SHIFT + 1))) seen_row = 1'b1;
  end

  // dedicated selects move on the falling edge only, the address on the rising one
  always @(sel0_n, sel2_n, sel3_n) begin
    if (rst === 1'b0) check(clock, 0, "strobe edge");
  end
  always @(addr_out) begin
    if (rst === 1'b0) check(clock, 1, "addr edge");
  end

  task automatic check(logic [31:0] got, logic [31:0] exp, string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // one request; n counts falling edges from take to answer
  task automatic access(logic [23:0] a, logic wr, logic [1:0] sz, logic [31:0] wd);
    @(negedge clock);
    seen_oe = 1'b0;
    seen_sel1 = 1'b0;
    seen_drv = 1'b0;
    seen_row = 1'b0;
    req = '{addr: a, write: wr, size: sz, burst: 1'b0, wdata: wd};
    req_valid = 1'b1;
    check(req_ready, 1, "ready");
    @(negedge clock);
    req_valid = 1'b0;
    n = 1;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    r = rsp;
  endtask

  task automatic set_cfg(logic [2:0] s, logic [7:0] b, logic [3:0] wcnt, logic ea, logic p16);
    @(negedge clock);
    cfg_sel = s;
    cfg_data = '{valid: 1'b1, base: b, mask: 8'h00, wait_cycle_count: wcnt, ext_ack: ea,
      port16: p16};
    cfg_wr = 1'b1;
    @(negedge clock);
    cfg_wr = 1'b0;
  endtask

  task automatic test_done();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    $display("unexpected at %0t: timeout", $time);
    test_done();
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    sysbus_hit = 1'b0;
    cfg_wr = 1'b0;
    cfg_sel = 3'h0;
    cfg_data = '0;
    pinfn_wr = 1'b0;
    pinfn_data = '0;
    gp_nine = 1'b0;
    gp_one = 1'b0;
    gp_forty = 1'b0;
    ack_en = 1'b1;
    ack_delay = 4'h0;
    err_en = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    for (int i = 0; i < 256; i++) pm.mem[i] = 16'(16'h1000 + i);
    repeat (16) @(posedge clock);
    @(negedge clock);
    check({pinfn, read_write_n, sel0_n, sel1_n, oe_n, data_oe_n}, {3'h0, 20'hfffff}, "rst");
    rst = 1'b0;
    // acknowledge held low must be ignored after reset
    access(24'h000010, 1'b0, cseb_pkg::SIZE_WORD, 32'h0);
    check(n, 19, "reset len");
    check({r.error, r.rdata[15:0], seen_oe}, {1'b0, 16'h1008, 1'b1}, "rd0");
    ack_en = 1'b0;
    for (int w = 0; w < 16; w += 5) begin
      set_cfg(3'h0, 8'h00, 4'(w), 1'b0, 1'b1);
      access(24'h000010, 1'b0, cseb_pkg::SIZE_WORD, 32'h0);
      check(n, 4 + w, "len");
    end
    access(24'h000040, 1'b1, cseb_pkg::SIZE_LONG, 32'ha1b2c3d4);
    check({pm.mem[32], pm.mem[33]}, 32'ha1b2c3d4, "long wr");
    check({seen_drv, seen_oe}, 2'b10, "wr strobes");
    access(24'h000040, 1'b0, cseb_pkg::SIZE_LONG, 32'h0);
    check(r.rdata, 32'ha1b2c3d4, "long rd");
    access(24'h000041, 1'b0, cseb_pkg::SIZE_BYTE, 32'h0);
    check(r.rdata[7:0], 8'hb2, "odd byte");
    access(24'h000040, 1'b0, cseb_pkg::SIZE_BYTE, 32'h0);
    check(r.rdata[7:0], 8'ha1, "even byte");
    access(24'h120000, 1'b0, cseb_pkg::SIZE_WORD, 32'h0);
    check({r.error, n[3:0]}, {1'b1, 4'h1}, "no match");
    sysbus_hit = 1'b1;
    access(24'h120000, 1'b0, cseb_pkg::SIZE_WORD, 32'h0);
    check(r.error, 0, "sysbus hit");
    sysbus_hit = 1'b0;
    err_en = 1'b1;
    access(24'h000010, 1'b0, cseb_pkg::SIZE_WORD, 32'h0);
    check(r.error, 1, "err in");
    err_en = 1'b0;
    // slow external acknowledge, then immediate ones back to back
    set_cfg(3'h1, 8'h01, 4'h0, 1'b1, 1'b1);
    ack_en = 1'b1;
    ack_delay = 4'h3;
    access(24'h010020, 1'b0, cseb_pkg::SIZE_WORD, 32'h0);
    check({r.error, r.rdata[15:0], seen_sel1}, {1'b0, 16'h1010, 1'b1}, "ext ack");
    check(n >= 7, 1, "ack sync");
    ack_delay = 4'h0;
    for (int k = 0; k < 2; k++) begin
      access(24'h010022, 1'b0, cseb_pkg::SIZE_WORD, 32'h0);
      check({r.error, r.rdata[15:0]}, {1'b0, 16'h1011}, "ack again");
    end
    // dram bank must finish with no acknowledge at all
    ack_en = 1'b0;
    set_cfg(3'h4, 8'h02, 4'h0, 1'b1, 1'b1);
    access(24'h020000, 1'b0, cseb_pkg::SIZE_WORD, 32'h0);
    check({n < 40, r.error, seen_sel1, seen_row}, 4'h9, "dram");
    // byte-wide region: a longword is four upper-lane bytes, one address apart
    set_cfg(3'h2, 8'h03, 4'h0, 1'b0, 1'b0);
    access(24'h030040, 1'b0, cseb_pkg::SIZE_LONG, 32'h0);
    check(r.rdata, 32'ha1a1c3c3, "narrow rd");
    check(n, 13, "narrow len");
    @(negedge clock);
    pinfn_data = '{rw_gpio: 1'b1, sel1_gpio: 1'b1, oe_gpio: 1'b1};
    pinfn_wr = 1'b1;
    @(negedge clock);
    pinfn_wr = 1'b0;
    @(negedge clock);
    check({pinfn, read_write_n, sel1_n, oe_n}, 6'h38, "gpio lo");
    gp_nine = 1'b1;
    gp_one = 1'b1;
    gp_forty = 1'b1;
    @(negedge clock);
    check({read_write_n, sel1_n, oe_n}, 3'h7, "gpio hi");
    test_done();
  end
endmodule
